// ---- gain_mgmt_map.svh ----
// Timing and limit constants for the supply-driven gain manager
`ifndef GAIN_MGMT_MAP_SVH
`define GAIN_MGMT_MAP_SVH
`define CLK_FREQ_HZ      250000000
`define AVG_STEP_S       10
`define INST_PERIOD_S    30
`define LOWBAT_REPEAT_S  300
`define TICK_CYCLES      250000000
`define INST_STEP_DB     3
`define INST_STEP_MAX    2
`define AVG_STEP_MAX     18
`endif

// ---- gain_mgmt_pkg.sv ----
// Types for the supply-driven gain manager
package gain_mgmt_pkg;
   typedef logic [1:0] inst_cnt_t;
   typedef logic [4:0] avg_cnt_t;
   typedef logic [6:0] atten_t;
   typedef enum logic [1:0] {
      INST_IDLE   = 2'b00,
      INST_HOLD   = 2'b01,
      INST_WATCH  = 2'b10
   } inst_state_t;
endpackage : gain_mgmt_pkg

// ---- sec_tick.sv ----
// One-second enable pulse divider
`timescale 1ns/10ps
module sec_tick #(
   parameter int unsigned CYCLES = 250000000
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   output logic      tick
);
   logic [31:0] cnt_q;

   always_ff @(posedge clk) begin
      if (sys_rst || cnt_q == CYCLES - 1) begin
         cnt_q <= 32'h0;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick <= 1'b0;
      end else begin
         tick <= (cnt_q == CYCLES - 1);
      end
   end
endmodule : sec_tick

// ---- gain_mgmt.sv ----
// Supply-driven gain reduction, mute and low-battery indicator control
`timescale 1ns/10ps
`include "gain_mgmt_map.svh"

// Function
// R1 - Average ok, instantaneous dip: immediate 3 dB
// R2 - Ignore instantaneous dips for 30 s
// R3 - Dip next period: second step, restart hold (inst_sec_q not restarted, hold ends with current period)
// R4 - At most two instantaneous steps
// R5 - Above 1.1 V whole period: clear steps
// R6 - Two steps, above 1.0 V: drop one
// R7 - Average low: add 1 dB every 10 s
// R8 - Eighteen average steps: stop and mute
// R9 - Average high: unmute before removing steps
// R10 - Average high: remove 1 dB every 10 s
// R11 - Average in band: hold count and mute
// R12 - Instantaneous and average counters independent
// R13 - Shutdown level forces hardware reset
// R14 - Enabled notification requests low-battery indicator
// R15 - Repeat indicator every five minutes
// R16 - Mute while programming, restore afterwards
// R17 - Resume memory if supply stayed above 0.6 V
// R18 - Attenuation is three times inst plus avg
// R19 - Intervals from free-running timebase, reset clears
module gain_mgmt
   import gain_mgmt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES   = `TICK_CYCLES,
   parameter int unsigned AVG_STEP_S    = `AVG_STEP_S,
   parameter int unsigned INST_PERIOD_S = `INST_PERIOD_S,
   parameter int unsigned LOWBAT_S      = `LOWBAT_REPEAT_S
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic inst_below_095,
   input  wire logic inst_above_100,
   input  wire logic inst_above_110,
   input  wire logic inst_below_shutdown,
   input  wire logic avg_below_095,
   input  wire logic avg_above_110,
   input  wire logic supply_above_060,
   input  wire logic lowbat_below_thr,
   input  wire logic notify_en,
   input  wire logic prog_active,
   output logic      hw_reset_req,
   output atten_t    atten_db,
   output logic      audio_mute,
   output logic      prog_fade_mute,
   output logic      lowbat_ind_req,
   output logic      resume_prev_mem,
   output inst_cnt_t inst_steps,
   output avg_cnt_t  avg_steps
);
   // Pin synchronisers, stage one read only by stage two
   logic [11:0] meta_q;
   logic [11:0] sync_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // Supply-good level at reset, else false memory loss
         meta_q <= 12'h020;
         sync_q <= 12'h020;
      end else begin
         meta_q <= {inst_below_095, inst_above_100, inst_above_110,
                    inst_below_shutdown, avg_below_095, avg_above_110,
                    supply_above_060, lowbat_below_thr, notify_en,
                    prog_active, 2'b00};
         sync_q <= meta_q;
      end
   end

   logic s_ib95;
   logic s_ia100;
   logic s_ia110;
   logic s_ishut;
   logic s_ab95;
   logic s_aa110;
   logic s_up060;
   logic s_lowbat;
   logic s_notify;
   logic s_prog;
   assign s_ib95   = sync_q[11];
   assign s_ia100  = sync_q[10];
   assign s_ia110  = sync_q[9];
   assign s_ishut  = sync_q[8];
   assign s_ab95   = sync_q[7];
   assign s_aa110  = sync_q[6];
   assign s_up060  = sync_q[5];
   assign s_lowbat = sync_q[4];
   assign s_notify = sync_q[3];
   assign s_prog   = sync_q[2];

   // Free-running timebase
   // R19 one second tick
   logic sec_en;
   sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (sec_en)
   );

   function automatic logic [8:0] wrap_inc(input logic [8:0] v,
                                           input int unsigned lim);
      wrap_inc = (v == 9'(lim - 1)) ? 9'h000 : v + 9'h001;
   endfunction : wrap_inc

   // Instantaneous path: hold timer, then watch a full period
   inst_state_t inst_st_q;
   logic [8:0]  inst_sec_q;
   logic        stay110_q;
   logic        stay100_q;
   logic        inst_end;
   assign inst_end = sec_en && inst_sec_q == 9'(INST_PERIOD_S - 1);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inst_sec_q <= 9'h000;
      end else if (inst_st_q == INST_IDLE) begin
         inst_sec_q <= 9'h000;
      end else if (sec_en) begin
         inst_sec_q <= wrap_inc(inst_sec_q, INST_PERIOD_S);
      end
   end

   // R12 instantaneous counter alone
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inst_st_q  <= INST_IDLE;
         inst_steps <= 2'h0;
         stay110_q  <= 1'b1;
         stay100_q  <= 1'b1;
      end else begin
         case (inst_st_q)
            INST_IDLE: begin
               // R1 immediate step
               if (s_ib95 && !s_ab95) begin
                  inst_steps <= 2'h1;
                  inst_st_q  <= INST_HOLD;
               end
            end
            INST_HOLD: begin
               // R2 dips ignored during hold
               if (inst_end) begin
                  inst_st_q <= INST_WATCH;
                  stay110_q <= 1'b1;
                  stay100_q <= 1'b1;
               end
            end
            INST_WATCH: begin
               if (s_ib95 && !s_ab95) begin
                  // R3 second step
                  // R4 capped at two
                  if (inst_steps < 2'(`INST_STEP_MAX)) begin
                     inst_steps <= inst_steps + 2'h1;
                  end
                  inst_st_q <= INST_HOLD;
               end else if (inst_end) begin
                  stay110_q <= 1'b1;
                  stay100_q <= 1'b1;
                  // R5 full restore
                  if (stay110_q && s_ia110) begin
                     inst_steps <= 2'h0;
                     inst_st_q  <= INST_IDLE;
                  // R6 back to one step
                  end else if (inst_steps == 2'h2 && stay100_q && s_ia100) begin
                     inst_steps <= 2'h1;
                  end
               end else begin
                  stay110_q <= stay110_q & s_ia110;
                  stay100_q <= stay100_q & s_ia100;
               end
            end
            default: begin
               inst_st_q <= INST_IDLE;
            end
         endcase
      end
   end

   // Average path, ten-second interval
   logic [8:0] avg_sec_q;
   logic       avg_end;
   logic       avg_act;
   assign avg_act = s_ab95 || s_aa110;
   assign avg_end = sec_en && avg_sec_q == 9'(AVG_STEP_S - 1);

   always_ff @(posedge clk) begin
      if (sys_rst || !avg_act) begin
         avg_sec_q <= 9'h000;
      end else if (sec_en) begin
         avg_sec_q <= wrap_inc(avg_sec_q, AVG_STEP_S);
      end
   end

   // R12 average counter alone
   // R11 nothing changes in band
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avg_steps  <= 5'h00;
         audio_mute <= 1'b0;
      end else if (s_ab95) begin
         // R7 one step per interval
         // R8 cap then mute
         if (avg_steps == 5'(`AVG_STEP_MAX)) begin
            audio_mute <= 1'b1;
         end else if (avg_end) begin
            avg_steps <= avg_steps + 5'h01;
            if (avg_steps == 5'(`AVG_STEP_MAX - 1)) begin
               audio_mute <= 1'b1;
            end
         end
      end else if (s_aa110) begin
         // R9 unmute first
         if (audio_mute) begin
            audio_mute <= 1'b0;
         // R10 one step back per interval
         end else if (avg_end && avg_steps != 5'h00) begin
            avg_steps <= avg_steps - 5'h01;
         end
      end
   end

   // R18 combined attenuation
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         atten_db <= 7'h00;
      end else begin
         atten_db <= 7'(inst_steps) * 7'(`INST_STEP_DB) + 7'(avg_steps);
      end
   end

   // R13 shutdown forces reset
   // R17 remember whether 0.6 V held
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hw_reset_req    <= 1'b0;
         resume_prev_mem <= 1'b1;
      end else begin
         hw_reset_req <= s_ishut;
         if (!s_up060) begin
            resume_prev_mem <= 1'b0;
         end
      end
   end

   // R14 low-battery request
   // R15 five-minute repeat
   logic        lowbat_q;
   logic [8:0]  lb_sec_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lowbat_q       <= 1'b0;
         lb_sec_q       <= 9'h000;
         lowbat_ind_req <= 1'b0;
      end else begin
         lowbat_ind_req <= 1'b0;
         if (!lowbat_q) begin
            if (s_notify && s_lowbat) begin
               lowbat_q       <= 1'b1;
               lowbat_ind_req <= 1'b1;
               lb_sec_q       <= 9'h000;
            end
         end else if (sec_en) begin
            lb_sec_q <= wrap_inc(lb_sec_q, LOWBAT_S);
            lowbat_ind_req <= (lb_sec_q == 9'(LOWBAT_S - 1));
         end
      end
   end

   // R16 fader mute while programming
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prog_fade_mute <= 1'b0;
      end else begin
         prog_fade_mute <= s_prog;
      end
   end

   AST_INST_CAP: assert property (@(posedge clk) disable iff (sys_rst)
      inst_steps <= 2'h2) else $error("inst steps over two"); // R4
   AST_AVG_CAP: assert property (@(posedge clk) disable iff (sys_rst)
      avg_steps <= 5'h12) else $error("avg steps over 18"); // R8
   AST_MUTE_AT_MAX: assert property (@(posedge clk) disable iff (sys_rst)
      (avg_steps == 5'h12 && s_ab95) |=> audio_mute)
      else $error("no mute at max"); // R8
   AST_UNMUTE_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
      (audio_mute && s_aa110) |=> avg_steps == $past(avg_steps))
      else $error("step removed before unmute"); // R9
   AST_BAND_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      (!s_ab95 && !s_aa110) |=> $stable(avg_steps) && $stable(audio_mute))
      else $error("avg changed in band"); // R11
   AST_HOLD_IGNORE: assert property (@(posedge clk) disable iff (sys_rst)
      (inst_st_q == INST_HOLD && !inst_end) |=> $stable(inst_steps))
      else $error("step during hold"); // R2
   AST_IMMEDIATE: assert property (@(posedge clk) disable iff (sys_rst)
      (inst_st_q == INST_IDLE && s_ib95 && !s_ab95) |=> inst_steps == 2'h1)
      else $error("no immediate step"); // R1
   AST_ATTEN: assert property (@(posedge clk) disable iff (sys_rst)
      atten_db == 7'(3 * $past(inst_steps) + $past(avg_steps)))
      else $error("attenuation mismatch"); // R18
   AST_PROG_MUTE: assert property (@(posedge clk) disable iff (sys_rst)
      s_prog |=> prog_fade_mute) else $error("no programming mute"); // R16
   AST_SHUT: assert property (@(posedge clk) disable iff (sys_rst)
      s_ishut |=> hw_reset_req) else $error("no reset on shutdown"); // R13

   // Instantaneous path checks
   AST_SECOND_STEP: assert property (@(posedge clk) disable iff (sys_rst) // R3
      (inst_st_q == INST_WATCH && s_ib95 && !s_ab95 && inst_steps == 2'h1)
      |=> inst_steps == 2'h2)
      else $error("no second step");
   AST_RESTORE: assert property (@(posedge clk) disable iff (sys_rst) // R5
      (inst_st_q == INST_WATCH && !(s_ib95 && !s_ab95) && inst_end
       && stay110_q && s_ia110) |=> inst_steps == 2'h0)
      else $error("steps not cleared");
   AST_MID: assert property (@(posedge clk) disable iff (sys_rst) // R6
      (inst_st_q == INST_WATCH && !(s_ib95 && !s_ab95) && inst_end
       && !(stay110_q && s_ia110) && inst_steps == 2'h2
       && stay100_q && s_ia100) |=> inst_steps == 2'h1)
      else $error("no drop to one step");

   // Average path checks
   AST_AVG_ADD: assert property (@(posedge clk) disable iff (sys_rst) // R7
      (s_ab95 && avg_end && avg_steps < 5'h12)
      |=> avg_steps == 5'($past(avg_steps) + 5'h01))
      else $error("no average step added");
   AST_AVG_SUB: assert property (@(posedge clk) disable iff (sys_rst) // R10
      (s_aa110 && !s_ab95 && !audio_mute && avg_end && avg_steps != 5'h00)
      |=> avg_steps == 5'($past(avg_steps) - 5'h01))
      else $error("no average step removed");

   // Indicator, timebase and restart checks
   AST_LOWBAT_FIRST: assert property (@(posedge clk) disable iff (sys_rst) // R14
      (!lowbat_q && s_notify && s_lowbat) |=> lowbat_ind_req)
      else $error("no low-battery request");
   AST_LOWBAT_PULSE: assert property (@(posedge clk) disable iff (sys_rst) // R15
      lowbat_ind_req |=> !lowbat_ind_req)
      else $error("indicator request too long");
   AST_TICK_PULSE: assert property (@(posedge clk) disable iff (sys_rst) // R19
      sec_en |=> !sec_en)
      else $error("tick wider than one cycle");
   AST_RESUME_STICKY: assert property (@(posedge clk) disable iff (sys_rst) // R17
      !resume_prev_mem |=> !resume_prev_mem)
      else $error("memory resume flag came back");

   COV_TWO_STEPS: cover property (@(posedge clk) inst_steps == 2'h2);
   COV_AVG_MUTE: cover property (@(posedge clk) audio_mute);
   COV_LOWBAT: cover property (@(posedge clk) lowbat_ind_req);
   COV_UNMUTE: cover property (@(posedge clk) $fell(audio_mute));
endmodule : gain_mgmt

// ---- supply_model.sv ----
// Supply monitor model: millivolt levels to comparator outputs
`timescale 1ns/10ps
module supply_model #(
   parameter logic [11:0] SHUTDOWN_MV = 12'h320,
   parameter logic [11:0] LOWBAT_MV   = 12'h41a
) (
   input  wire logic [11:0] inst_mv,
   input  wire logic [11:0] avg_mv,
   output logic             inst_below_095,
   output logic             inst_above_100,
   output logic             inst_above_110,
   output logic             inst_below_shutdown,
   output logic             avg_below_095,
   output logic             avg_above_110,
   output logic             supply_above_060,
   output logic             lowbat_below_thr
);
   assign inst_below_095      = inst_mv < 12'h3b6;
   assign inst_above_100      = inst_mv > 12'h3e8;
   assign inst_above_110      = inst_mv > 12'h44c;
   assign inst_below_shutdown = inst_mv < SHUTDOWN_MV;
   assign avg_below_095       = avg_mv < 12'h3b6;
   assign avg_above_110       = avg_mv > 12'h44c;
   assign supply_above_060    = inst_mv > 12'h258;
   assign lowbat_below_thr    = avg_mv < LOWBAT_MV;
endmodule : supply_model

// ---- test_supply_driven_gain_reduction.sv ----
// Testbench for the supply-driven gain manager
`timescale 1ns/10ps
module test_supply_driven_gain_reduction;
   import gain_mgmt_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [11:0] inst_mv = 12'h4b0;
   logic [11:0] avg_mv = 12'h3e8;
   logic        notify_en = 1'b0;
   logic        prog_active = 1'b0;
   logic        ib095, ia100, ia110, ishut, ab095, aa110, s060, lowbat;
   logic        hw_reset_req, audio_mute, prog_fade_mute, lowbat_ind_req;
   logic        resume_prev_mem;
   atten_t      atten_db;
   inst_cnt_t   inst_steps;
   avg_cnt_t    avg_steps;
   int          fails = 0;
   int          checked = 0;
   int          pulses = 0;

   always #2 clk = ~clk;
   always @(posedge clk) if (lowbat_ind_req === 1'b1) pulses++;

   supply_model supply_model_inst (.inst_mv(inst_mv), .avg_mv(avg_mv),
      .inst_below_095(ib095), .inst_above_100(ia100),
      .inst_above_110(ia110), .inst_below_shutdown(ishut),
      .avg_below_095(ab095), .avg_above_110(aa110),
      .supply_above_060(s060), .lowbat_below_thr(lowbat));

   // Short timebase keeps the run small
   gain_mgmt #(.TICK_CYCLES(4), .AVG_STEP_S(3), .INST_PERIOD_S(4),
      .LOWBAT_S(5)) gain_mgmt_inst (.clk(clk), .sys_rst(sys_rst),
      .inst_below_095(ib095), .inst_above_100(ia100),
      .inst_above_110(ia110), .inst_below_shutdown(ishut),
      .avg_below_095(ab095), .avg_above_110(aa110),
      .supply_above_060(s060), .lowbat_below_thr(lowbat),
      .notify_en(notify_en), .prog_active(prog_active),
      .hw_reset_req(hw_reset_req), .atten_db(atten_db),
      .audio_mute(audio_mute), .prog_fade_mute(prog_fade_mute),
      .lowbat_ind_req(lowbat_ind_req),
      .resume_prev_mem(resume_prev_mem), .inst_steps(inst_steps),
      .avg_steps(avg_steps));

   task automatic chk(input string what, input logic [6:0] exp, got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic stop_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic wait_inst(input inst_cnt_t v, input int lim);
      for (int i = 0; i < lim && inst_steps !== v; i++) @(negedge clk);
      chk("inst_steps", 7'(v), 7'(inst_steps));
   endtask : wait_inst

   task automatic wait_avg(input avg_cnt_t v, input int lim);
      for (int i = 0; i < lim && avg_steps !== v; i++) @(negedge clk);
      chk("avg_steps", 7'(v), 7'(avg_steps));
   endtask : wait_avg

   task automatic t_inst;
      inst_mv = 12'h384;
      wait_inst(2'h1, 8);
      cyc(2);
      chk("atten", 7'h03, atten_db);
      cyc(8);
      chk("inst hold", 7'h01, 7'(inst_steps));
      wait_inst(2'h2, 60);
      cyc(2);
      chk("atten", 7'h06, atten_db);
      cyc(80);
      chk("inst max", 7'h02, 7'(inst_steps));
      inst_mv = 12'h41a;
      wait_inst(2'h1, 80);
      cyc(40);
      chk("inst mid", 7'h01, 7'(inst_steps));
      inst_mv = 12'h4b0;
      wait_inst(2'h0, 80);
   endtask : t_inst

   task automatic t_avg;
      int i;
      avg_mv = 12'h384;
      wait_avg(5'h01, 20);
      chk("mute early", 7'h00, 7'(audio_mute));
      wait_avg(5'h12, 300);
      cyc(2);
      chk("mute", 7'h01, 7'(audio_mute));
      chk("atten", 7'h12, atten_db);
      avg_mv = 12'h3e8;
      cyc(40);
      chk("avg band", 7'h12, 7'(avg_steps));
      chk("mute band", 7'h01, 7'(audio_mute));
      inst_mv = 12'h384;
      wait_inst(2'h1, 8);
      cyc(2);
      chk("avg kept", 7'h12, 7'(avg_steps));
      chk("atten", 7'h15, atten_db);
      inst_mv = 12'h4b0;
      avg_mv = 12'h4b0;
      for (i = 0; i < 6 && audio_mute !== 1'b0; i++) @(negedge clk);
      chk("unmute", 7'h00, 7'(audio_mute));
      chk("avg at unmute", 7'h12, 7'(avg_steps));
      wait_avg(5'h00, 300);
      wait_inst(2'h0, 80);
      chk("no notify", 7'h00, 7'(pulses));
   endtask : t_avg

   task automatic t_prog;
      prog_active = 1'b1;
      cyc(2);
      chk("fade early", 7'h00, 7'(prog_fade_mute));
      cyc(1);
      chk("fade", 7'h01, 7'(prog_fade_mute));
      prog_active = 1'b0;
      cyc(4);
      chk("fade off", 7'h00, 7'(prog_fade_mute));
   endtask : t_prog

   task automatic t_lowbat;
      int n;
      avg_mv = 12'h3e8;
      notify_en = 1'b1;
      n = 0;
      while (pulses < 2 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("first pulses", 7'h02, 7'(pulses));
      n = 0;
      while (pulses < 3 && n < 30) begin
         @(negedge clk);
         n++;
      end
      chk("repeat gap", 7'h14, 7'(n));
   endtask : t_lowbat

   task automatic t_shut;
      inst_mv = 12'h2bc;
      cyc(4);
      chk("hw reset", 7'h01, 7'(hw_reset_req));
      chk("resume", 7'h01, 7'(resume_prev_mem));
      inst_mv = 12'h1f4;
      cyc(4);
      chk("resume lost", 7'h00, 7'(resume_prev_mem));
      sys_rst = 1'b1;
      inst_mv = 12'h4b0;
      cyc(2);
      sys_rst = 1'b0;
      cyc(1);
      chk("hw reset clr", 7'h00, 7'(hw_reset_req));
      chk("resume rst", 7'h01, 7'(resume_prev_mem));
      chk("atten rst", 7'h00, atten_db);
   endtask : t_shut

   initial begin
      cyc(2);
      sys_rst = 1'b0;
      chk("atten rst", 7'h00, atten_db);
      chk("resume rst", 7'h01, 7'(resume_prev_mem));
      t_inst();
      t_avg();
      t_prog();
      t_lowbat();
      t_shut();
      stop_test();
   end

   // Whole run needs about 800 cycles
   initial begin
      #40000;
      fails++;
      stop_test();
   end
endmodule : test_supply_driven_gain_reduction
